//--- err_report_pkg.sv
/*
 error-reporting constants for the serial link controller: status word bits,
 octal codes, command types and timing. assumes a 40 MHz system clock.
*/
`default_nettype none
package err_report_pkg;
	localparam int          CLK_HZ           = 40_000_000;
	localparam int          WORD_W           = 16;
	localparam int          BIT_DISCONNECT   = 6;
	localparam int          BIT_START_RX     = 7;
	localparam int          BIT_MISSING_MEM  = 8;
	localparam int          BIT_PROCEDURE    = 9;
	localparam logic [15:0] CODE_DISCONNECT  = 16'o100;
	localparam logic [15:0] CODE_START_RX    = 16'o200;
	localparam logic [15:0] CODE_MISSING_MEM = 16'o400;
	localparam logic [15:0] CODE_PROCEDURE   = 16'o1000;
	localparam logic [15:0] ERR_WORD_RESET   = 16'h0000;
	localparam logic [1:0]  CMD_BUFFER       = 2'b00;
	localparam logic [1:0]  CMD_SETUP        = 2'b01;
	localparam logic [1:0]  CMD_INVALID      = 2'b10;
	localparam logic [1:0]  CMD_BASE         = 2'b11;
	localparam logic [15:0] HOST_LOC_A       = 16'o24;
	localparam logic [15:0] HOST_LOC_B       = 16'o26;
	localparam int          STALL_NS         = 20_000;
	localparam int          STALL_CYCLES     = STALL_NS / (1_000_000_000 / CLK_HZ);
	typedef enum logic [1:0] {
		ST_INIT    = 2'b00,
		ST_BASED   = 2'b01,
		ST_RUNNING = 2'b10,
		ST_HALTED  = 2'b11
	} link_state_e;
endpackage : err_report_pkg
`default_nettype wire

//--- link_err_report.sv
/*
 error reporting for a synchronous serial link controller: detects the four
 upper control-out errors and presents them in the upper data port word.
 assumes command, buffer and protocol strobes come from logic on clk_sys;
 the data-set-ready pin is asynchronous and is synchronised here.
*/
// Notes on behaviour
// R01 - error word shown in upper data port
// R02 - remote carrier loss after start: bit 6
// R03 - start message while running: fatal bit 7
// R04 - bus timeout reported at buffer end, bit 8
// R05 - timeouts checked only on data buffers
// R06 - each missing-memory access stalls bus 20us
// R07 - unhonourable input command: fatal bit 9
// R08 - bad type, early commands, second base
// R09 - remote: drop terminal ready on procedure error
// R10 - second base shuts down as procedure error
// R11 - fatal error leaves running; reinit needed
// R12 - non-fatal errors only inform host
// R13 - each report is a control-out transfer
`timescale 1ns/1ps
`default_nettype none
module link_err_report
	import err_report_pkg::*;
#(
	parameter int STALL_CNT = STALL_CYCLES
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        master_clear,
	input  wire logic        remote_mode,
	input  wire logic        data_set_ready,
	input  wire logic        cmd_valid,
	input  wire logic [1:0]  input_command_byte,
	input  wire logic        setup_done,
	input  wire logic        start_msg_rx,
	input  wire logic        bus_timeout,
	input  wire logic        access_is_buffer,
	input  wire logic [15:0] access_addr,
	input  wire logic        buffer_end,
	input  wire logic        report_taken,
	output logic             report_valid,
	output logic [15:0]      control_out_error_word,
	output logic             link_running,
	output logic             terminal_ready,
	output logic             bus_stall
);
	////////////////////////////////////////////////////////////////////////
	// elaboration checks
	if (STALL_CNT < 1) begin : g_bad_stall
		$error("STALL_CNT must be at least 1");
	end
	if (WORD_W != 16) begin : g_bad_width
		$error("error word must be 16 bits");
	end
	if (BIT_PROCEDURE >= WORD_W) begin : g_bad_top_bit
		$error("procedure bit outside the word");
	end
	if (CODE_DISCONNECT != (16'h0001 << BIT_DISCONNECT)) begin : g_bad_disc
		$error("disconnect code and bit disagree");
	end
	if (CODE_START_RX != (16'h0001 << BIT_START_RX)) begin : g_bad_start
		$error("start code and bit disagree");
	end
	if (CODE_MISSING_MEM != (16'h0001 << BIT_MISSING_MEM)) begin : g_bad_mem
		$error("memory code and bit disagree");
	end
	if (CODE_PROCEDURE != (16'h0001 << BIT_PROCEDURE)) begin : g_bad_proc
		$error("procedure code and bit disagree");
	end
	if (BIT_DISCONNECT >= BIT_PROCEDURE) begin : g_bad_order
		$error("error bits out of order");
	end
	if (HOST_LOC_A == HOST_LOC_B) begin : g_bad_locs
		$error("excluded host locations must differ");
	end
	if (CMD_INVALID == CMD_BASE) begin : g_bad_cmds
		$error("invalid and base codes must differ");
	end
	if (ERR_WORD_RESET != 16'h0000) begin : g_bad_reset
		$error("error word must reset clear");
	end

	link_state_e     state_r;
	link_state_e     state_nxt;
	logic            dsr_s1_r;
	logic            dsr_s2_r;
	logic            dsr_prev_r;
	logic            mem_pend_r;
	logic [31:0]     stall_r;
	logic [15:0]     word_r;
	logic            valid_r;
	logic            proc_err_r;
	logic            dtr_r;

	////////////////////////////////////////////////////////////////////////
	// shared decodes
	function automatic logic is_excluded_loc(input logic [15:0] addr);
		is_excluded_loc = (addr == HOST_LOC_A) | (addr == HOST_LOC_B);
	endfunction : is_excluded_loc

	function automatic logic [15:0] code_if(
		input logic        hit,
		input logic [15:0] code
	);
		code_if = hit ? code : 16'h0000;
	endfunction : code_if

	function automatic logic is_state(
		input link_state_e cur,
		input link_state_e want
	);
		is_state = (cur == want);
	endfunction : is_state

	////////////////////////////////////////////////////////////////////////
	// event decode
	wire        in_init    = is_state(state_r, ST_INIT);
	wire        in_running = is_state(state_r, ST_RUNNING);

	// link and bus events
	wire        dsr_fall   = dsr_prev_r & ~dsr_s2_r;
	wire        disc_ev    = remote_mode & dsr_fall & in_running; // [R02]
	wire        start_ev   = start_msg_rx & in_running;           // [R03]
	wire        loc_excl   = is_excluded_loc(access_addr);
	wire        mem_hit    = bus_timeout & access_is_buffer & ~loc_excl; // [R05]
	wire        mem_ev     = buffer_end & (mem_pend_r | mem_hit);  // [R04]

	// command checks
	wire        is_base    = (input_command_byte == CMD_BASE);
	wire        bad_type   = cmd_valid & (input_command_byte == CMD_INVALID);
	wire        early      = cmd_valid & in_init & ~is_base;
	wire        second_b   = cmd_valid & ~in_init & is_base;       // [R10]
	wire        proc_ev    = bad_type | early | second_b;          // [R08]
	wire        fatal_ev   = start_ev | mem_ev | proc_ev;
	wire [15:0] new_bits   = code_if(disc_ev, CODE_DISCONNECT) |
	                         code_if(start_ev, CODE_START_RX) |
	                         code_if(mem_ev, CODE_MISSING_MEM) |
	                         code_if(proc_ev, CODE_PROCEDURE);     // [R07]
	wire        any_ev     = |new_bits;

	////////////////////////////////////////////////////////////////////////
	// protocol state
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_INIT:    if (cmd_valid & ~proc_ev) state_nxt = ST_BASED;
			ST_BASED:   if (setup_done) state_nxt = ST_RUNNING;
			ST_RUNNING: state_nxt = ST_RUNNING;
			ST_HALTED:  state_nxt = ST_HALTED;
		endcase
		if (fatal_ev) state_nxt = ST_HALTED;                            // [R11]
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n || master_clear) state_r <= ST_INIT;
		else state_r <= state_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// pin synchroniser
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			dsr_s1_r   <= 1'b0;
			dsr_s2_r   <= 1'b0;
			dsr_prev_r <= 1'b0;
		end else begin
			dsr_s1_r   <= data_set_ready;
			dsr_s2_r   <= dsr_s1_r;
			dsr_prev_r <= dsr_s2_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// missing-memory deferral and bus stall
	always_ff @(posedge clk_sys) begin
		if (!rst_n || master_clear) mem_pend_r <= 1'b0;
		else if (buffer_end) mem_pend_r <= 1'b0;
		else if (mem_hit) mem_pend_r <= 1'b1;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) stall_r <= 32'h0000_0000;
		else if (mem_hit) stall_r <= 32'(STALL_CNT);                    // [R06]
		else if (stall_r != 32'h0000_0000) stall_r <= stall_r - 32'h0000_0001;
	end

	////////////////////////////////////////////////////////////////////////
	// report word; new events win over the host's take
	wire [15:0] word_keep = report_taken ? ERR_WORD_RESET : word_r;

	always_ff @(posedge clk_sys) begin
		if (!rst_n || master_clear) word_r <= ERR_WORD_RESET;
		else if (any_ev) word_r <= word_keep | new_bits;    // [R13]
		else if (report_taken) word_r <= ERR_WORD_RESET;     // [R12]
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n || master_clear) valid_r <= 1'b0;
		else if (any_ev) valid_r <= 1'b1;
		else if (report_taken) valid_r <= 1'b0;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n || master_clear) proc_err_r <= 1'b0;
		else if (proc_ev) proc_err_r <= 1'b1;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n || master_clear) dtr_r <= 1'b1;
		else dtr_r <= ~(remote_mode & (proc_err_r | proc_ev)); // [R09]
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign control_out_error_word = word_r;                             // [R01]
	assign report_valid           = valid_r;
	assign link_running           = in_running;
	assign terminal_ready         = dtr_r;                              // [R09]
	assign bus_stall              = (stall_r != 32'h0000_0000);
endmodule : link_err_report
`default_nettype wire

//--- link_err_report_properties.sv
/* checker for link_err_report error reports
 assumes bind onto the design, one clk_sys domain */
`timescale 1ns/1ps
`default_nettype none
module link_err_report_properties
	import err_report_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        remote_mode,
	input wire logic        cmd_valid,
	input wire logic [1:0]  input_command_byte,
	input wire logic        start_msg_rx,
	input wire logic        report_valid,
	input wire logic [15:0] control_out_error_word,
	input wire logic        link_running,
	input wire logic        terminal_ready
);
	wire logic [15:0] w = control_out_error_word;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_bad; cmd_valid && input_command_byte == CMD_INVALID; endsequence
	sequence s_rebase; cmd_valid && input_command_byte == CMD_BASE; endsequence
	AST_BAD_TYPE: assert property (s_bad |=> w[BIT_PROCEDURE] && report_valid)
		else $error("procedure bit missing");
	AST_REBASE: assert property (s_rebase ##0 link_running |=>
		w[BIT_PROCEDURE] && !link_running) else $error("second base kept");
	AST_START: assert property (start_msg_rx && link_running |=>
		w[BIT_START_RX] && !link_running) else $error("start not fatal");
	AST_DTR: assert property (s_bad ##0 remote_mode |=> !terminal_ready)
		else $error("terminal ready kept");
	AST_FIELDS: assert property (w[15:10] == '0 && w[5:0] == '0)
		else $error("stray word bits");
	AST_VALID: assert property (report_valid == (w != 16'h0000))
		else $error("valid and word disagree");
	AST_DISC: assert property ($rose(w == CODE_DISCONNECT) |-> link_running)
		else $error("disconnect halted link");
	AST_MEM: assert property ($rose(w[BIT_MISSING_MEM]) |-> !link_running)
		else $error("memory error not fatal");
endmodule : link_err_report_properties
bind link_err_report link_err_report_properties i_props (.*);
`default_nettype wire

//--- host_report_model.sv
/* host side: takes each control-out report
 assumes clk_sys domain */
`timescale 1ns/1ps
`default_nettype none
module host_report_model (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic take_en,
	input  wire logic report_valid,
	output var logic  report_taken
);
	always_ff @(posedge clk_sys) begin
		report_taken <= rst_n && take_en && report_valid && !report_taken;
	end
endmodule : host_report_model
`default_nettype wire

//--- test_link_err_report.sv
/* bench for link_err_report
 assumes host_report_model takes reports */
`timescale 1ns/1ps
`default_nettype none
module test_link_err_report;
	import err_report_pkg::*;
	logic clk_sys = 0, rst_n = 0, master_clear = 0, remote_mode = 1;
	logic data_set_ready = 1, access_is_buffer = 1, take_en = 1;
	logic [1:0] input_command_byte = '0;
	logic [15:0] access_addr = 16'h1000, control_out_error_word;
	logic [4:0] stb = '0;
	logic report_valid, link_running, terminal_ready, bus_stall, report_taken;
	int mismatches = 0, num_checks = 0, n;
	logic [15:0] xa [3] = '{HOST_LOC_A, HOST_LOC_B, 16'h1000};
	logic [19:0] rows [7] = '{
		{2'd0, CMD_BUFFER, CODE_PROCEDURE}, {2'd0, CMD_SETUP, CODE_PROCEDURE},
		{2'd0, CMD_INVALID, CODE_PROCEDURE}, {2'd2, CMD_BASE, CODE_PROCEDURE},
		{2'd2, CMD_INVALID, CODE_PROCEDURE}, {2'd2, CMD_BUFFER, 16'h0000},
		{2'd1, CMD_SETUP, 16'h0000}};
	link_err_report #(.STALL_CNT(4)) i_link_err_report (.clk_sys, .rst_n,
		.master_clear, .remote_mode, .data_set_ready, .cmd_valid(stb[4]),
		.input_command_byte, .setup_done(stb[1]), .start_msg_rx(stb[0]),
		.bus_timeout(stb[2]), .access_is_buffer, .access_addr,
		.buffer_end(stb[3]), .report_taken, .report_valid,
		.control_out_error_word, .link_running, .terminal_ready, .bus_stall);
	host_report_model i_host_report_model (.clk_sys, .rst_n, .take_en,
		.report_valid, .report_taken);
	always #12.5 clk_sys = ~clk_sys;
	task automatic chk(string nm, logic [15:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic pulse(logic [4:0] m, logic [1:0] t = 2'b00);
		@(posedge clk_sys) stb <= m;
		input_command_byte <= t;
		@(posedge clk_sys) stb <= '0;
		#1;
	endtask : pulse
	task automatic init(int lvl);
		@(posedge clk_sys) master_clear <= 1'b1;
		@(posedge clk_sys) master_clear <= 1'b0;
		if (lvl > 0) pulse(5'h10, CMD_BASE);
		if (lvl > 1) pulse(5'h02);
		repeat (3) @(posedge clk_sys);
		#1;
	endtask : init
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done
	initial begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		#1;
		chk("word", control_out_error_word, ERR_WORD_RESET);
		foreach (rows[i]) begin
			init(int'(rows[i][19:18]));
			pulse(5'h10, rows[i][17:16]);
			chk("word", control_out_error_word, rows[i][15:0]);
			chk("dtr", 16'(terminal_ready), 16'(rows[i][15:0] == 0));
		end
		init(2);
		pulse(5'h01);
		chk("word", control_out_error_word, CODE_START_RX);
		chk("run", 16'(link_running), 16'h0000);
		init(1);
		pulse(5'h01);
		chk("word", control_out_error_word, 16'h0000);
		init(2);
		pulse(5'h04);
		chk("stall", 16'(bus_stall), 16'h0001);
		chk("word", control_out_error_word, 16'h0000);
		pulse(5'h08);
		chk("word", control_out_error_word, CODE_MISSING_MEM);
		repeat (2) @(posedge clk_sys);
		#1;
		chk("stall", 16'(bus_stall), 16'h0000);
		for (n = 0; n < 3; n++) begin
			init(2);
			access_addr <= xa[n];
			access_is_buffer <= n < 2;
			pulse(5'h04);
			pulse(5'h08);
			chk("word", control_out_error_word, 16'h0000);
		end
		init(2);
		data_set_ready <= 1'b0;
		for (n = 0; n < 10 && report_valid !== 1'b1; n++) @(posedge clk_sys) #1;
		chk("word", control_out_error_word, CODE_DISCONNECT);
		if (n == 10) begin
			mismatches++;
			test_done();
		end
		chk("run", 16'(link_running), 16'h0001);
		remote_mode <= 1'b0;
		init(0);
		pulse(5'h10, CMD_INVALID);
		chk("dtr", 16'(terminal_ready), 16'h0001);
		test_done();
	end
	initial begin
		#1_000_000;
		mismatches++;
		test_done();
	end
endmodule : test_link_err_report
`default_nettype wire
